//--- uart_sid_pkg.sv
/*
  Constants for the serial transceiver status, interrupt and data-holding block:
  register offsets, status and control bit positions, reset values and widths.
  Assumes a 32-bit APB register bus and byte addresses on PADDR.
*/
`default_nettype none

package uart_sid_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // bus and register map
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [ADDR_W-1:0] LINE_STATUS_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] CHAR_DATA_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] LINE_CTRL_OFS = 8'h20;

  ////////////////////////////////////////////////////////////////////////////
  // line_status bit positions
  localparam int unsigned ST_W = 10;
  localparam int unsigned ST_PARITY = 0;
  localparam int unsigned ST_FRAMING = 1;
  localparam int unsigned ST_NOISE = 2;
  localparam int unsigned ST_OVERRUN = 3;
  localparam int unsigned ST_QUIET = 4;
  localparam int unsigned ST_RXFULL = 5;
  localparam int unsigned ST_SENT = 6;
  localparam int unsigned ST_TXEMPTY = 7;
  localparam int unsigned ST_BREAK = 8;
  localparam int unsigned ST_CTS = 9;
  localparam logic [ST_W-1:0] STATUS_RST = 10'h0C0;
  // bits that a written zero clears
  localparam logic [ST_W-1:0] WR0_CLR_MASK = 10'h360;
  // bits cleared by the status-read then data-read sequence
  localparam logic [ST_W-1:0] RD_SEQ_MASK = 10'h01F;
  // flag events that cancel an armed clearing sequence
  localparam logic [ST_W-1:0] EVENT_MASK = 10'h07F;

  ////////////////////////////////////////////////////////////////////////////
  // line_ctrl bit positions
  localparam int unsigned CTRL_W = 13;
  localparam int unsigned C_PARITY_IRQ = 0;
  localparam int unsigned C_TXE_IRQ = 1;
  localparam int unsigned C_SENT_IRQ = 2;
  localparam int unsigned C_RXFULL_IRQ = 3;
  localparam int unsigned C_QUIET_IRQ = 4;
  localparam int unsigned C_BREAK_IRQ = 5;
  localparam int unsigned C_CTS_IRQ = 6;
  localparam int unsigned C_ERR_IRQ = 7;
  localparam int unsigned C_FLOW_IN = 8;
  localparam int unsigned C_MULTIBUF = 9;
  localparam int unsigned C_PARITY_EN = 10;
  localparam int unsigned C_PARITY_ODD = 11;
  localparam int unsigned C_WORD9 = 12;
  localparam logic [CTRL_W-1:0] CTRL_RST = 13'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // character layout
  localparam int unsigned CHAR_W = 9;
  localparam int unsigned MSB_8BIT = 7;
  localparam int unsigned MSB_9BIT = 8;
  localparam logic [CHAR_W-1:0] CHAR_RST = 9'h000;
  localparam int unsigned SYNC_DEPTH = 3;

endpackage

`default_nettype wire

//--- uart_status_irq_data.sv
/*
  Status flags, interrupt combining and data holding registers of a serial
  transceiver, reached over APB. Assumes the shift engines on the same clock
  give one-cycle strobes for transfers and line events, and that the peer
  ready pin is asynchronous.
*/
// Implementation choice: the APB register port.
//
// Behaviour
// - all transmit, receive and error events share one interrupt output
// - a flag drives the interrupt only while its enable is set
// - clear-to-send change flag bit 9 sets on peer-ready toggle while flow-in is enabled; write 0 clears
// - line-break flag bit 8 sets on break detection; write 0 clears; own enable
// - transmit-holding-empty bit 7 sets on move to shifter; data write clears
// - frame-sent bit 6 sets at frame end; status read then data write, or 0
// - receive-full bit 5 sets on receive transfer; data read or write 0 clears
// - software uses write-zero clearing of bits 6 and 5 only in multibuffer
// - quiet-line bit 4 sets on idle; clear by sequence; rearms after receive-full
// - overrun bit 3 sets if word arrives while receive-full; held word kept
// - overrun interrupts via receive-full enable; status then data read clears
// - noise bit 2 sets on noisy frame; sequence clears; no single-buffer irq
// - framing bit 1 sets on desync, noise or break; sequence clears
// - a word with framing error and overrun sets only overrun
// - in multibuffer mode noise, overrun, framing interrupt via error enable
// - parity fault bit 0 sets on parity error; sequence clears; own enable
// - status resets to 0x00C0; bits 31 to 10 read zero
// - data register 9 bits; write loads transmit, read returns receive holding
// - with parity on, written msb is replaced by computed parity
// - with parity on, read msb is the received parity bit
// - variant without flow control omits the clear-to-send change flag
// - parity sits at bit 8 for 9-bit words, bit 7 for 8-bit words
`timescale 1ns/1ps
`default_nettype none

module uart_status_irq_data
  import uart_sid_pkg::*;
#(
  parameter bit HAS_FLOW_CTRL = 1'b1
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // apb slave
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [DATA_W-1:0] PWDATA,
  output logic [DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // transmit engine
  input wire logic TX_TAKE,
  input wire logic FRAME_DONE,
  output logic [CHAR_W-1:0] TX_CHAR,
  output logic TX_PENDING,
  // receive engine
  input wire logic RX_WORD_VALID,
  input wire logic [CHAR_W-1:0] RX_WORD,
  input wire logic RX_NOISE,
  input wire logic RX_FRAMING,
  input wire logic RX_PARITY,
  input wire logic IDLE_DETECT,
  input wire logic BREAK_DETECT,
  // line pin
  input wire logic PEER_READY_N_INPUT,
  // configuration to engines
  output logic PARITY_ENABLE,
  output logic PARITY_ODD,
  output logic WORD9,
  output logic FLOW_IN_ENABLE,
  output logic RX_DMA_REQUEST_EN,
  // interrupt
  output logic IRQ
);

  typedef struct packed {
    logic [SYNC_DEPTH-1:0] sync;
    logic cts_level;
    logic [ST_W-1:0] st;
    logic [CTRL_W-1:0] ctrl;
    logic [CHAR_W-1:0] tx_holding_reg;
    logic [CHAR_W-1:0] rx_holding_reg;
    logic armed;
    logic idle_armed;
    logic irq;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic tx_pending;
  } state_t;

  // peer-ready pin idles high; a low reset value would fake a toggle
  localparam state_t STATE_RST = '{
    sync: '1, cts_level: 1'b1, st: STATUS_RST, ctrl: CTRL_RST,
    tx_holding_reg: CHAR_RST, rx_holding_reg: CHAR_RST, armed: 1'b0, idle_armed: 1'b0,
    irq: 1'b0, prdata: '0, pready: 1'b0, pslverr: 1'b0, tx_pending: 1'b0};

  state_t s_r;
  state_t s_nxt;

  logic setup;
  logic access;
  logic hit_sr;
  logic hit_dr;
  logic hit_ctrl;
  logic sr_rd;
  logic sr_wr;
  logic dr_rd;
  logic dr_wr;
  logic ctrl_wr;
  logic cts_toggle;
  logic rx_load;
  logic rx_over;
  logic event_any;
  logic par_bit;
  logic [ST_W-1:0] set_v;
  logic [ST_W-1:0] clr_v;
  logic [CHAR_W-1:0] wr_char;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_nxt = s_r;
    setup = PSEL & ~PENABLE;
    access = PSEL & PENABLE & s_r.pready;
    hit_sr = (PADDR == LINE_STATUS_OFS);
    hit_dr = (PADDR == CHAR_DATA_OFS);
    hit_ctrl = (PADDR == LINE_CTRL_OFS);
    sr_rd = access & ~PWRITE & hit_sr;
    sr_wr = access & PWRITE & hit_sr;
    dr_rd = access & ~PWRITE & hit_dr;
    dr_wr = access & PWRITE & hit_dr;
    ctrl_wr = access & PWRITE & hit_ctrl;

    // pin synchroniser: only stages two and three are compared
    s_nxt.sync = {s_r.sync[SYNC_DEPTH-2:0], PEER_READY_N_INPUT};
    cts_toggle = (s_r.sync[1] == s_r.sync[2]) && (s_r.sync[2] != s_r.cts_level);
    if (s_r.sync[1] == s_r.sync[2]) begin
      s_nxt.cts_level = s_r.sync[2];
    end

    // a read in the same cycle frees the holding register, so no overrun
    rx_load = RX_WORD_VALID & (~s_r.st[ST_RXFULL] | dr_rd);
    rx_over = RX_WORD_VALID & s_r.st[ST_RXFULL] & ~dr_rd;

    set_v = '0;
    set_v[ST_PARITY] = rx_load & RX_PARITY;
    set_v[ST_FRAMING] = rx_load & RX_FRAMING;
    set_v[ST_NOISE] = rx_load & RX_NOISE;
    set_v[ST_OVERRUN] = rx_over;
    set_v[ST_QUIET] = IDLE_DETECT & s_r.idle_armed;
    set_v[ST_RXFULL] = rx_load;
    set_v[ST_SENT] = FRAME_DONE;
    set_v[ST_TXEMPTY] = TX_TAKE & ~dr_wr;
    set_v[ST_BREAK] = BREAK_DETECT;
    // peer ready toggled, absent without flow control
    set_v[ST_CTS] = HAS_FLOW_CTRL & cts_toggle & s_r.ctrl[C_FLOW_IN];
    event_any = |(set_v & EVENT_MASK);

    clr_v = '0;
    if (sr_wr) begin
      clr_v = WR0_CLR_MASK & ~PWDATA[ST_W-1:0];
    end
    // armed sequence, cancelled by a new event
    if (dr_rd && s_r.armed && !event_any) begin
      clr_v = clr_v | RD_SEQ_MASK;
    end
    if (dr_wr && s_r.armed && !event_any) begin
      clr_v[ST_SENT] = 1'b1;
    end
    if (dr_rd) begin
      clr_v[ST_RXFULL] = 1'b1;
    end
    if (dr_wr) begin
      clr_v[ST_TXEMPTY] = 1'b1;
    end
    // set wins over clear, except bit 7, where a data write beats a transfer to the shifter
    s_nxt.st = (s_r.st & ~clr_v) | set_v;
    // registered copy, so the pending output leaves a flop directly
    s_nxt.tx_pending = ~s_nxt.st[ST_TXEMPTY];

    if (sr_rd && !event_any) begin
      s_nxt.armed = 1'b1;
    end else if (dr_rd || dr_wr || event_any) begin
      s_nxt.armed = 1'b0;
    end
    if (set_v[ST_RXFULL]) begin
      s_nxt.idle_armed = 1'b1;
    end else if (set_v[ST_QUIET]) begin
      s_nxt.idle_armed = 1'b0;
    end

    if (s_r.ctrl[C_WORD9]) begin
      par_bit = (^PWDATA[MSB_9BIT-1:0]) ^ s_r.ctrl[C_PARITY_ODD];
    end else begin
      par_bit = (^PWDATA[MSB_8BIT-1:0]) ^ s_r.ctrl[C_PARITY_ODD];
    end
    wr_char = PWDATA[CHAR_W-1:0];
    if (s_r.ctrl[C_PARITY_EN]) begin
      if (s_r.ctrl[C_WORD9]) begin
        wr_char[MSB_9BIT] = par_bit;
      end else begin
        wr_char[MSB_8BIT] = par_bit;
      end
    end
    if (dr_wr) begin
      s_nxt.tx_holding_reg = wr_char;
    end
    if (rx_load) begin
      s_nxt.rx_holding_reg = RX_WORD;
      if (!s_r.ctrl[C_WORD9]) begin
        s_nxt.rx_holding_reg[MSB_9BIT] = 1'b0;
      end
    end
    if (ctrl_wr) begin
      s_nxt.ctrl = PWDATA[CTRL_W-1:0];
    end

    // each flag gated by its enable
    s_nxt.irq = (s_nxt.st[ST_PARITY] & s_nxt.ctrl[C_PARITY_IRQ])
      | (s_nxt.st[ST_TXEMPTY] & s_nxt.ctrl[C_TXE_IRQ])
      | (s_nxt.st[ST_SENT] & s_nxt.ctrl[C_SENT_IRQ])
      | ((s_nxt.st[ST_RXFULL] | s_nxt.st[ST_OVERRUN]) & s_nxt.ctrl[C_RXFULL_IRQ])
      | (s_nxt.st[ST_QUIET] & s_nxt.ctrl[C_QUIET_IRQ])
      | (s_nxt.st[ST_BREAK] & s_nxt.ctrl[C_BREAK_IRQ])
      | (s_nxt.st[ST_CTS] & s_nxt.ctrl[C_CTS_IRQ])
      | (s_nxt.ctrl[C_MULTIBUF] & s_nxt.ctrl[C_ERR_IRQ]
         & (s_nxt.st[ST_NOISE] | s_nxt.st[ST_OVERRUN] | s_nxt.st[ST_FRAMING]));

    // answer in the access phase; read data is taken at setup
    s_nxt.pready = setup;
    s_nxt.pslverr = setup & ~(hit_sr | hit_dr | hit_ctrl);
    s_nxt.prdata = '0;
    if (setup && !PWRITE) begin
      if (hit_sr) begin
        s_nxt.prdata[ST_W-1:0] = s_r.st;
      end else if (hit_dr) begin
        s_nxt.prdata[CHAR_W-1:0] = s_r.rx_holding_reg;
      end else if (hit_ctrl) begin
        s_nxt.prdata[CTRL_W-1:0] = s_r.ctrl;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      s_r <= STATE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign PRDATA = s_r.prdata;
  assign PREADY = s_r.pready;
  assign PSLVERR = s_r.pslverr;
  assign TX_CHAR = s_r.tx_holding_reg;
  assign TX_PENDING = s_r.tx_pending;
  assign PARITY_ENABLE = s_r.ctrl[C_PARITY_EN];
  assign PARITY_ODD = s_r.ctrl[C_PARITY_ODD];
  assign WORD9 = s_r.ctrl[C_WORD9];
  assign FLOW_IN_ENABLE = s_r.ctrl[C_FLOW_IN];
  assign RX_DMA_REQUEST_EN = s_r.ctrl[C_MULTIBUF];
  assign IRQ = s_r.irq;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  sequence status_read_s;
    sr_rd && !event_any;
  endsequence

  sequence quiet_gap_s;
    !event_any && !sr_rd;
  endsequence

  sequence data_write_s;
    dr_wr && !event_any && !FRAME_DONE;
  endsequence

  a_rx_irq_follow: assert property (
    (rx_load && s_r.ctrl[C_RXFULL_IRQ] && !ctrl_wr) |=> IRQ)
    else $error("receive-full did not raise interrupt");

  a_irq_all_masked: assert property (
    (s_r.ctrl == CTRL_RST) |-> !IRQ)
    else $error("interrupt high with every enable clear");

  a_cts_toggle_set: assert property (
    (cts_toggle && s_r.ctrl[C_FLOW_IN] && HAS_FLOW_CTRL) |=> s_r.st[ST_CTS])
    else $error("peer ready toggle did not set change flag");

  a_break_flag_set: assert property (
    BREAK_DETECT |=> s_r.st[ST_BREAK])
    else $error("break detect not flagged");

  a_txe_write_clear: assert property (
    dr_wr |=> !s_r.st[ST_TXEMPTY] && TX_PENDING)
    else $error("data write left transmit holding empty");

  a_sent_seq_clear: assert property (
    status_read_s ##1 quiet_gap_s[*2] ##1 data_write_s |=> !s_r.st[ST_SENT])
    else $error("status read then data write did not clear frame sent");

  a_overrun_keeps: assert property (
    rx_over |=> s_r.st[ST_OVERRUN] && $stable(s_r.rx_holding_reg))
    else $error("overrun lost held word or flag");

  a_fe_only_ovr: assert property (
    (rx_over && !s_r.st[ST_FRAMING]) |=> !s_r.st[ST_FRAMING])
    else $error("framing set on overrun word");

  a_status_upper_zero: assert property (
    (setup && !PWRITE && hit_sr) |=> PREADY && (PRDATA[DATA_W-1:ST_W] == '0))
    else $error("status read upper bits not zero");

  a_parity_insert: assert property (
    (dr_wr && s_r.ctrl[C_PARITY_EN] && !s_r.ctrl[C_WORD9] && !ctrl_wr)
      |=> TX_CHAR[MSB_8BIT] == ((^TX_CHAR[MSB_8BIT-1:0]) ^ s_r.ctrl[C_PARITY_ODD]))
    else $error("parity not placed at bit 7");

  a_rx_full_set: assert property (
    rx_load |=> s_r.st[ST_RXFULL])
    else $error("receive transfer did not set receive-full");

  a_quiet_no_rearm: assert property (
    (IDLE_DETECT && !s_r.idle_armed && !s_r.st[ST_QUIET]) |=> !s_r.st[ST_QUIET])
    else $error("quiet line set again without a received word");

  a_seq_clears_errs: assert property (
    (dr_rd && s_r.armed && !event_any) |=> ((s_r.st & RD_SEQ_MASK) == '0))
    else $error("status then data read left error flags set");

  a_parity_flag_set: assert property (
    (rx_load && RX_PARITY) |=> s_r.st[ST_PARITY])
    else $error("parity error not flagged");

  a_err_irq_multi: assert property (
    (s_nxt.ctrl[C_MULTIBUF] && s_nxt.ctrl[C_ERR_IRQ] && s_nxt.st[ST_NOISE]) |=> IRQ)
    else $error("multibuffer noise did not raise interrupt");

endmodule

`default_nettype wire

//--- serial_peer_model.sv
/*
  Behavioural transmit engine on the far side of the holding registers.
  Assumes the core clock, and a holding register that reports pending data.
*/
`timescale 1ns/1ps
`default_nettype none

module serial_peer_model #(
  parameter int FRAME = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // holding side
  input wire logic pending,
  input wire logic [7:0] hold,
  output logic take,
  output logic done
);
  int cnt;
  logic busy;

  ////////////////////////////////////////////////////////////////////////////
  // one frame in flight at a time, so a new word waits for the line
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      busy <= 1'b0;
      take <= 1'b0;
      done <= 1'b0;
    end else begin
      take <= 1'b0;
      done <= 1'b0;
      if (busy) begin
        cnt <= cnt - 1;
        if (cnt == 1) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end else if (pending && !take) begin
        if (cnt >= int'(hold)) begin
          take <= 1'b1;
          busy <= 1'b1;
          cnt <= FRAME;
        end else begin
          cnt <= cnt + 1;
        end
      end else begin
        cnt <= 0;
      end
    end
  end
endmodule

`default_nettype wire

//--- uart_status_irq_data_test.sv
/*
  Self-checking bench for the status, interrupt and data block.
  Assumes the peer model drives the transmit strobes; the bench drives APB and receive.
*/
`timescale 1ns/1ps
`default_nettype none

module uart_status_irq_data_test
  import uart_sid_pkg::*;
;
  logic CORE_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic [ADDR_W-1:0] PADDR = '0;
  logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [DATA_W-1:0] PWDATA = '0;
  logic [DATA_W-1:0] PRDATA;
  logic PREADY, PSLVERR, TX_TAKE, FRAME_DONE, TX_PENDING, IRQ;
  logic PARITY_ENABLE, PARITY_ODD, WORD9, FLOW_IN_ENABLE, RX_DMA_REQUEST_EN;
  logic [CHAR_W-1:0] TX_CHAR, c, w1, w2;
  logic RX_WORD_VALID = 1'b0, RX_NOISE = 1'b0, RX_FRAMING = 1'b0, RX_PARITY = 1'b0;
  logic [CHAR_W-1:0] RX_WORD = '0;
  logic IDLE_DETECT = 1'b0, BREAK_DETECT = 1'b0, PEER_READY_N_INPUT = 1'b1;
  logic [7:0] hold = 8'h0A;
  logic [31:0] seed = 32'h0000004D;
  logic [DATA_W-1:0] d;
  logic [38:0] expq[$];
  logic [38:0] got;
  // configuration outputs expected from the last control write
  logic [4:0] cfg_x = '0;
  logic [CHAR_W-1:0] txq[$];
  int err_count = 0;
  int compares = 0;

  always #5 CORE_CLK = ~CORE_CLK;

  uart_status_irq_data uut (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .PADDR(PADDR), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .TX_TAKE(TX_TAKE), .FRAME_DONE(FRAME_DONE), .TX_CHAR(TX_CHAR),
    .TX_PENDING(TX_PENDING), .RX_WORD_VALID(RX_WORD_VALID), .RX_WORD(RX_WORD),
    .RX_NOISE(RX_NOISE), .RX_FRAMING(RX_FRAMING), .RX_PARITY(RX_PARITY),
    .IDLE_DETECT(IDLE_DETECT), .BREAK_DETECT(BREAK_DETECT),
    .PEER_READY_N_INPUT(PEER_READY_N_INPUT), .PARITY_ENABLE(PARITY_ENABLE),
    .PARITY_ODD(PARITY_ODD), .WORD9(WORD9), .FLOW_IN_ENABLE(FLOW_IN_ENABLE),
    .RX_DMA_REQUEST_EN(RX_DMA_REQUEST_EN), .IRQ(IRQ));

  serial_peer_model peer (.clk(CORE_CLK), .rst_n(RST_N), .pending(TX_PENDING),
    .hold(hold), .take(TX_TAKE), .done(FRAME_DONE));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [33:0] e(input logic i, input logic [31:0] v);
    return {i, 1'b0, v};
  endfunction

  task automatic chk(input logic [38:0] x, input logic [38:0] g);
    compares++;
    if (g !== x) begin
      err_count++;
      $display("ERROR %0t: read %h expected %h", $time, g, x);
    end
  endtask

  task automatic chkc(input logic [CHAR_W-1:0] x, input logic [CHAR_W-1:0] g);
    compares++;
    if (g !== x) begin
      err_count++;
      $display("ERROR %0t: sent %h expected %h", $time, g, x);
    end
  endtask

  task automatic results();
    if (err_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge CORE_CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= v;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    do @(posedge CORE_CLK); while (PREADY !== 1'b1);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (w && a == LINE_CTRL_OFS) begin
      cfg_x = {v[C_PARITY_EN], v[C_PARITY_ODD], v[C_WORD9], v[C_FLOW_IN], v[C_MULTIBUF]};
    end
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [33:0] x);
    expq.push_back({cfg_x, x});
    apb(1'b0, a, '0);
  endtask

  task automatic rx(input logic [CHAR_W-1:0] w, input logic [2:0] nfp);
    @(posedge CORE_CLK);
    RX_WORD_VALID <= 1'b1;
    RX_WORD <= w;
    {RX_NOISE, RX_FRAMING, RX_PARITY} <= nfp;
    @(posedge CORE_CLK);
    RX_WORD_VALID <= 1'b0;
    RX_WORD <= ~w;
    {RX_NOISE, RX_FRAMING, RX_PARITY} <= 3'h0;
  endtask

  task automatic ev(input logic [1:0] ib);
    @(posedge CORE_CLK);
    {IDLE_DETECT, BREAK_DETECT} <= ib;
    @(posedge CORE_CLK);
    {IDLE_DETECT, BREAK_DETECT} <= 2'h0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // outputs looked at mid-cycle, where they are settled
  always @(negedge CORE_CLK) begin
    if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE) begin
      got = {PARITY_ENABLE, PARITY_ODD, WORD9, FLOW_IN_ENABLE, RX_DMA_REQUEST_EN,
        IRQ, PSLVERR, PRDATA};
      chk(expq.pop_front(), got); // read data
    end
    if (TX_TAKE === 1'b1) begin
      chkc(txq.pop_front(), TX_CHAR); // sent char
    end
  end

  initial begin
    #200000;
    err_count++;
    results();
  end

  initial begin
    repeat (8) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    rd(LINE_STATUS_OFS, e(1'b0, 32'h000000C0)); // reset value
    rd(8'h10, {2'b01, 32'h00000000}); // unmapped
    apb(1'b1, LINE_CTRL_OFS, 32'h00000008);
    w1 = CHAR_W'(xs() & 32'h000000FF);
    w2 = CHAR_W'(xs() & 32'h000000FF);
    rx(w1, 3'h0);
    rd(LINE_STATUS_OFS, e(1'b1, 32'h000000E0)); // rx full
    rx(w2, 3'b010);
    rd(LINE_STATUS_OFS, e(1'b1, 32'h000000E8)); // overrun only
    rd(CHAR_DATA_OFS, e(1'b1, {23'h0, w1})); // held word
    rd(LINE_STATUS_OFS, e(1'b0, 32'h000000C0)); // cleared
    ev(2'b10);
    rd(LINE_STATUS_OFS, e(1'b0, 32'h000000D0)); // quiet
    rd(CHAR_DATA_OFS, e(1'b0, {23'h0, w1})); // sequence
    ev(2'b10);
    rd(LINE_STATUS_OFS, e(1'b0, 32'h000000C0)); // no rearm
    // a flag event between status and data read must keep the error flags
    apb(1'b1, LINE_CTRL_OFS, 32'h00000001);
    rx(w1, 3'b101);
    rd(LINE_STATUS_OFS, e(1'b1, 32'h000000E5)); // parity
    apb(1'b1, LINE_CTRL_OFS, 32'h00000000);
    rx(w2, 3'h0);
    rd(CHAR_DATA_OFS, e(1'b0, {23'h0, w1}));
    rd(LINE_STATUS_OFS, e(1'b0, 32'h000000CD)); // disarmed
    rd(CHAR_DATA_OFS, e(1'b0, {23'h0, w1})); // read
    rd(LINE_STATUS_OFS, e(1'b0, 32'h000000C0)); // cleared
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, LINE_CTRL_OFS, i ? 32'h00000280 : 32'h00000080);
      rx(w2, 3'b100);
      rd(LINE_STATUS_OFS, e(1'(i), i ? 32'h000000A4 : 32'h000000E4));
      apb(1'b1, LINE_STATUS_OFS, 32'h00000000);
      rd(LINE_STATUS_OFS, e(1'(i), 32'h00000084)); // write zero
      rd(CHAR_DATA_OFS, e(1'(i), {23'h0, w2})); // sequence
      rd(LINE_STATUS_OFS, e(1'b0, 32'h00000080)); // cleared
    end
    apb(1'b1, LINE_CTRL_OFS, 32'h00000160);
    ev(2'b01);
    rd(LINE_STATUS_OFS, e(1'b1, 32'h00000180)); // break
    apb(1'b1, LINE_STATUS_OFS, 32'h00000000);
    rd(LINE_STATUS_OFS, e(1'b0, 32'h00000080)); // write zero
    @(posedge CORE_CLK);
    PEER_READY_N_INPUT <= 1'b0;
    repeat (8) @(posedge CORE_CLK);
    rd(LINE_STATUS_OFS, e(1'b1, 32'h00000280)); // toggle
    apb(1'b1, LINE_STATUS_OFS, 32'hFFFFFFFF);
    rd(LINE_STATUS_OFS, e(1'b1, 32'h00000280)); // ones ignored
    apb(1'b1, LINE_STATUS_OFS, 32'h00000000);
    rd(LINE_STATUS_OFS, e(1'b0, 32'h00000080)); // write zero
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, LINE_CTRL_OFS, i ? 32'h00001C04 : 32'h00000404);
      rd(LINE_CTRL_OFS, e(1'(i), i ? 32'h00001C04 : 32'h00000404)); // ctrl
      d = xs() & (i ? 32'h000001FF : 32'h000000FF);
      c = i ? {~^d[7:0], d[7:0]} : {1'b0, ^d[6:0], d[6:0]};
      txq.push_back(c); // parity msb
      hold <= 8'(10 + 4 * i);
      rd(LINE_STATUS_OFS, e(1'(i), i ? 32'h000000C0 : 32'h00000080)); // arm
      apb(1'b1, CHAR_DATA_OFS, d);
      rd(LINE_STATUS_OFS, e(1'b0, 32'h00000000)); // write clears
      for (int k = 0; k < 100 && FRAME_DONE !== 1'b1; k++) @(negedge CORE_CLK);
      rd(LINE_STATUS_OFS, e(1'b1, 32'h000000C0)); // sent
    end
    results();
  end
endmodule

`default_nettype wire
